//--- rtl/pim_intx_msi.v
// Interrupt message signalling: configuration registers plus INTA and MSI message issue.
`include "pim_defs.vh"

module pim_intx_msi #(
   parameter NUM_CHAN = 1
) (
   // Clock, reset and enable.
   input wire clock_i,
   input wire resetn_i,
   input wire clk_en_i,
   // Configuration space access from the core.
   input wire cfg_wr_i,
   input wire cfg_rd_i,
   input wire [7:0] cfg_addr_i,
   input wire [3:0] cfg_be_i,
   input wire [31:0] cfg_wdata_i,
   output reg [31:0] cfg_rdata_o,
   // Masked interrupt sources, four per channel.
   input wire [4*NUM_CHAN-1:0] irq_src_i,
   // Message request toward the transaction layer.
   output wire msg_valid_o,
   input wire msg_ready_i,
   output reg [1:0] msg_kind_o,
   output reg [63:0] msi_addr_o,
   output reg [15:0] msi_data_o,
   // Mode indications.
   output wire msi_mode_o,
   output wire intx_pending_o
);

   localparam [1:0] KIND_INTA_ASSERT = 2'h0;
   localparam [1:0] KIND_INTA_DEASSERT = 2'h1;
   localparam [1:0] KIND_MSI = 2'h2;

   reg int_disable_r;
   reg [7:0] irq_line_r;
   reg msi_en_r;
   reg [2:0] mme_r;
   reg [29:0] addr_lo_r;
   reg [31:0] addr_hi_r;
   reg [15:0] data_r;
   reg req_prev_r;
   reg inta_sent_r;
   reg pend_r;

   // Byte-lane merge for configuration writes.
   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] be;
      integer k;
      begin
         merge = old_v;
         for (k = 0; k < 4; k = k + 1) begin
            if (be[k]) begin
               merge[8*k +: 8] = new_v[8*k +: 8];
            end
         end
      end
   endfunction

   // Combined request; the per-channel sources arrive already masked.
   wire comb_req = |irq_src_i;
   wire rise = comb_req & ~req_prev_r;
   wire [31:0] wmerge_cmd = merge({5'h00, int_disable_r, 10'h000, 16'h0000}, cfg_wdata_i,
      cfg_be_i);
   wire [31:0] wmerge_msi = merge({9'h000, mme_r, 3'h0, msi_en_r, 16'h0000}, cfg_wdata_i,
      cfg_be_i);
   wire [31:0] wmerge_lo = merge({addr_lo_r, 2'h0}, cfg_wdata_i, cfg_be_i);
   wire [31:0] wmerge_hi = merge(addr_hi_r, cfg_wdata_i, cfg_be_i);
   wire [31:0] wmerge_dat = merge({16'h0000, data_r}, cfg_wdata_i, cfg_be_i);
   wire [31:0] wmerge_line = merge({24'h00_0000, irq_line_r}, cfg_wdata_i, cfg_be_i);

   assign msg_valid_o = pend_r;
   assign msi_mode_o = msi_en_r;
   // Pending status is only meaningful in INTx mode.
   assign intx_pending_o = comb_req & ~msi_en_r;

   // Configuration register writes, dword-addressed with byte enables.
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         int_disable_r <= 1'b0;
         irq_line_r <= 8'h00;
         msi_en_r <= 1'b0;
         mme_r <= `PIM_MME_RST;
         addr_lo_r <= 30'h0000_0000;
         addr_hi_r <= 32'h0000_0000;
         data_r <= 16'h0000;
      end else if (clk_en_i && cfg_wr_i) begin
         case ({cfg_addr_i[7:2], 2'b00})
            `PIM_OFS_COMMAND: begin
               int_disable_r <= wmerge_cmd[`PIM_BIT_INT_DISABLE];
            end
            `PIM_OFS_IRQ_LINE: begin
               irq_line_r <= wmerge_line[7:0];
            end
            `PIM_OFS_MSI_CTRL - 8'h02: begin
               msi_en_r <= wmerge_msi[16 + `PIM_BIT_MSI_EN];
               mme_r <= wmerge_msi[22:20];
            end
            `PIM_OFS_MSI_ADDR_LO: begin
               addr_lo_r <= wmerge_lo[31:2];
            end
            `PIM_OFS_MSI_ADDR_HI: begin
               addr_hi_r <= wmerge_hi;
            end
            `PIM_OFS_MSI_DATA: begin
               data_r <= wmerge_dat[15:0];
            end
            default: begin
               data_r <= data_r;
            end
         endcase
      end
   end

   // Read data is registered; unmapped dwords read zero.
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_rdata_o <= 32'h0000_0000;
      end else if (clk_en_i && cfg_rd_i) begin
         case ({cfg_addr_i[7:2], 2'b00})
            `PIM_OFS_COMMAND: begin
               cfg_rdata_o <= {11'h000, 1'b1, intx_pending_o, 3'h0,
                  5'h00, int_disable_r, 10'h000};
            end
            `PIM_OFS_IRQ_LINE: begin
               cfg_rdata_o <= {16'h0000, `PIM_IRQ_PIN_VAL, irq_line_r};
            end
            `PIM_OFS_MSI_CTRL - 8'h02: begin
               cfg_rdata_o <= {8'h00, 1'b1, mme_r, `PIM_MMC_VAL, msi_en_r,
                  16'h0000};
            end
            `PIM_OFS_MSI_ADDR_LO: begin
               cfg_rdata_o <= {addr_lo_r, 2'b00};
            end
            `PIM_OFS_MSI_ADDR_HI: begin
               cfg_rdata_o <= addr_hi_r;
            end
            `PIM_OFS_MSI_DATA: begin
               cfg_rdata_o <= {16'h0000, data_r};
            end
            default: begin
               cfg_rdata_o <= 32'h0000_0000;
            end
         endcase
      end
   end

   // Message issue. A new edge while a message is waiting is folded into it; the
   // trade is that a very fast pulse train yields fewer messages than edges.
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         req_prev_r <= 1'b0;
         inta_sent_r <= 1'b0;
         pend_r <= 1'b0;
         msg_kind_o <= KIND_INTA_ASSERT;
         msi_addr_o <= 64'h0000_0000_0000_0000;
         msi_data_o <= 16'h0000;
      end else if (clk_en_i) begin
         req_prev_r <= comb_req;
         if (pend_r && msg_ready_i) begin
            pend_r <= 1'b0;
         end else if (!pend_r) begin
            if (msi_en_r) begin
               // Only the rising edge raises an MSI; clearing sources sends nothing.
               if (rise) begin
                  pend_r <= 1'b1;
                  msg_kind_o <= KIND_MSI;
                  msi_addr_o <= {addr_hi_r, addr_lo_r, 2'b00};
                  msi_data_o <= data_r;
               end
               inta_sent_r <= 1'b0;
            end else if (!int_disable_r && comb_req && !inta_sent_r) begin
               pend_r <= 1'b1;
               msg_kind_o <= KIND_INTA_ASSERT;
               inta_sent_r <= 1'b1;
            end else if (inta_sent_r && (!comb_req || int_disable_r)) begin
               pend_r <= 1'b1;
               msg_kind_o <= KIND_INTA_DEASSERT;
               inta_sent_r <= 1'b0;
            end
         end
      end
   end

endmodule // pim_intx_msi

//--- pkg/pim_defs.vh
// Constants for the interrupt message signalling block: register offsets, fields, reset values.
// Contract
// - Command bit 10 is read-write legacy interrupt disable, resets to zero; the code clears it on a write to offset 0x04 with cfg_be_i[1] low.
// - Status bit 3 shows INTx pending; always zero in MSI mode.
// - Status bit 4 reads constantly one, capability list present.
// - Interrupt line byte is plain read-write storage without behaviour.
// - Interrupt pin byte reads constantly 0x01, meaning INTA.
// - Message control bit 0 is MSI enable, read-write, resets zero.
// - Message control bits 3:1 read zero, one vector requested.
// - Message control bits 6:4 are read-write vector allocation, reset zero.
// - Message control bit 7 reads one, 64-bit address capable.
// - Lower address stores bits 31:2; bits 1:0 not writable.
// - Upper address register stores upper 32 bits of MSI address.
// - Data register stores 16-bit value placed in the MSI write.
// - After reset interrupts are signalled with INTA messages.
// - While MSI is enabled no INTx messages; MSI is used instead.
// - One MSI write per assertion of the combined request; the code folds an edge that arrives while a message waits into that message.
// - No message in MSI mode when pending status is cleared.
// - MSI write goes out when an INTA assert would have.
// - MSI is a memory write to programmed address with programmed data.
// - Each channel has four interrupt sources feeding the combined request.
`ifndef PIM_DEFS_VH
`define PIM_DEFS_VH
`define PIM_OFS_COMMAND 8'h04
`define PIM_OFS_STATUS 8'h06
`define PIM_OFS_IRQ_LINE 8'h3c
`define PIM_OFS_IRQ_PIN 8'h3d
`define PIM_OFS_MSI_CTRL 8'h72
`define PIM_OFS_MSI_ADDR_LO 8'h74
`define PIM_OFS_MSI_ADDR_HI 8'h78
`define PIM_OFS_MSI_DATA 8'h7c
`define PIM_BIT_INT_DISABLE 10
`define PIM_BIT_INT_STATUS 3
`define PIM_BIT_CAP_LIST 4
`define PIM_BIT_MSI_EN 0
`define PIM_BIT_MSI_64 7
`define PIM_IRQ_PIN_VAL 8'h01
`define PIM_MMC_VAL 3'h0
`define PIM_MME_RST 3'h0
`endif

//--- verification/pim_host_model.sv
// Far-side model that takes waiting messages after a chosen delay.
module pim_host_model (
   input logic clock_i, input logic resetn_i, input logic valid_i, input logic [1:0] slow_i,
   output logic ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_r;
   // Ready rises slow_i+1 cycles after valid to mimic a busy link; ready drops after each accept.
   always @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ready_o <= 1'b0;
         wait_r <= 2'd0;
      end else if (ready_o || !valid_i) begin
         ready_o <= 1'b0;
         wait_r <= 2'd0;
      end else if (wait_r == slow_i) begin
         ready_o <= 1'b1;
      end else begin
         wait_r <= wait_r + 2'd1;
      end
   end
endmodule // pim_host_model

//--- verification/pim_intx_msi_monitor.sv
// Checker for the interrupt message block, bound to its top module.
module pim_intx_msi_monitor #(parameter NUM_CHAN = 1) (
   input logic clock_i, input logic resetn_i, input logic clk_en_i, input logic cfg_rd_i,
   input logic [7:0] cfg_addr_i, input logic [31:0] cfg_rdata_o,
   input logic [4*NUM_CHAN-1:0] irq_src_i, input logic msg_valid_o, input logic msg_ready_i,
   input logic [1:0] msg_kind_o, input logic [63:0] msi_addr_o, input logic msi_mode_o,
   input logic intx_pending_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Sources come in already masked, so their OR is the combined request.
   wire req_any = |irq_src_i;
   wire rd_go = cfg_rd_i && clk_en_i;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   a_pend_live: assert property (intx_pending_o == (req_any && !msi_mode_o))
      else $error("pending flag wrong");
   a_status_read: assert property (rd_go && cfg_addr_i[7:2] == 6'h01 |=>
      cfg_rdata_o[20] && cfg_rdata_o[19] == $past(intx_pending_o)) else $error("status wrong");
   a_pin_read: assert property (rd_go && cfg_addr_i[7:2] == 6'h0f |=>
      cfg_rdata_o[15:8] == 8'h01) else $error("pin byte wrong");
   a_ctl_read: assert property (rd_go && cfg_addr_i[7:2] == 6'h1c |=>
      cfg_rdata_o[19:17] == 3'h0 && cfg_rdata_o[23]) else $error("control wrong");
   a_msi_only: assert property ($rose(msg_valid_o) && msi_mode_o |-> msg_kind_o == 2'd2)
      else $error("legacy message in MSI mode");
   a_msi_rise: assert property (clk_en_i && msi_mode_o && !msg_valid_o && req_any &&
      !$past(req_any) |=> msg_valid_o && msg_kind_o == 2'd2) else $error("MSI late");
   a_no_clear: assert property (msi_mode_o && !msg_valid_o && $fell(req_any) |=>
      !msg_valid_o) else $error("message on clear");
   a_msi_hold: assert property (msg_valid_o && msg_kind_o == 2'd2 && !msg_ready_i |=>
      msg_valid_o && $stable(msi_addr_o)) else $error("MSI dropped");
   c_msi: cover property (msg_valid_o && msg_ready_i && msg_kind_o == 2'd2);
   c_assert: cover property (msg_valid_o && msg_ready_i && msg_kind_o == 2'd0);
   c_deassert: cover property (msg_valid_o && msg_ready_i && msg_kind_o == 2'd1);
endmodule // pim_intx_msi_monitor

bind pim_intx_msi pim_intx_msi_monitor #(.NUM_CHAN(NUM_CHAN)) u_mon (
   .clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i), .cfg_rd_i(cfg_rd_i),
   .cfg_addr_i(cfg_addr_i), .cfg_rdata_o(cfg_rdata_o), .irq_src_i(irq_src_i),
   .msg_valid_o(msg_valid_o), .msg_ready_i(msg_ready_i), .msg_kind_o(msg_kind_o),
   .msi_addr_o(msi_addr_o), .msi_mode_o(msi_mode_o), .intx_pending_o(intx_pending_o));

//--- verification/pcie_intx_msi_signalling_tb_top.sv
// Self-checking bench for the interrupt message block.
module pcie_intx_msi_signalling_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0, resetn_i = 1'b0, en = 1'b1, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0;
   logic [7:0] cfg_addr_i = 8'h00;
   logic [3:0] cfg_be_i = 4'h0, irq_src_i = 4'h0;
   logic [31:0] cfg_wdata_i = 32'h0000_0000, cfg_rdata_o, a_lo, a_hi, d_w;
   logic [1:0] msg_kind_o, slow = 2'd0;
   logic [63:0] msi_addr_o;
   logic [15:0] msi_data_o;
   logic msg_valid_o, msg_ready_i, msi_mode_o, intx_pending_o, rd_p = 1'b0;
   logic [81:0] mq[$];
   logic [31:0] rq[$];
   int err_total = 0, comparisons = 0;
   always #20 clock_i = ~clock_i;
   pim_intx_msi u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(en),
      .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
      .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .irq_src_i(irq_src_i),
      .msg_valid_o(msg_valid_o), .msg_ready_i(msg_ready_i), .msg_kind_o(msg_kind_o),
      .msi_addr_o(msi_addr_o), .msi_data_o(msi_data_o), .msi_mode_o(msi_mode_o),
      .intx_pending_o(intx_pending_o));
   pim_host_model u_host (.clock_i(clock_i), .resetn_i(resetn_i), .valid_i(msg_valid_o),
      .slow_i(slow), .ready_o(msg_ready_i));
   task automatic chk(input logic [81:0] seen, input logic [81:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Each result takes the oldest note; an unexpected message meets an impossible kind.
   always @(posedge clock_i) begin
      rd_p <= cfg_rd_i;
      if (rd_p) chk({50'h0, cfg_rdata_o}, {50'h0, rq.pop_front()});
      if (msg_valid_o && msg_ready_i) chk({msg_kind_o, msg_kind_o == 2'd2 ?
         {msi_addr_o, msi_data_o} : 80'h0}, mq.size() ? mq.pop_front() : {2'd3, 80'h0});
   end
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      {cfg_wr_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} = {1'b1, a, be, d};
      @(posedge clock_i);
      #1 cfg_wr_i = 1'b0;
      @(posedge clock_i);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      {cfg_rd_i, cfg_addr_i} = {1'b1, a};
      @(posedge clock_i);
      #1 cfg_rd_i = 1'b0;
      @(posedge clock_i);
      #1;
   endtask
   // Bounded wait for all noted messages, then a quiet spell that must stay silent.
   task automatic drain;
      for (int i = 0; i < 60 && mq.size() != 0; i++) @(posedge clock_i);
      repeat (4) @(posedge clock_i);
      #1;
      chk(82'(mq.size()), 82'h0);
      if (mq.size() != 0) test_done();
   endtask
   initial begin
      void'($urandom(32'hc89e));
      repeat (3) @(posedge clock_i);
      #1 resetn_i = 1'b1;
      rd(8'h04, 32'h0010_0000);
      rd(8'h70, 32'h0080_0000);
      d_w = $urandom;
      wr(8'h3c, 4'hf, d_w);
      rd(8'h3c, {16'h0, 8'h01, d_w[7:0]});
      irq_src_i = 4'($urandom_range(15, 1));
      mq.push_back({2'd0, 80'h0});
      drain();
      rd(8'h04, 32'h0018_0000);
      irq_src_i = 4'h0;
      mq.push_back({2'd1, 80'h0});
      drain();
      wr(8'h04, 4'h2, 32'h0000_0400);
      irq_src_i = 4'h8;
      drain();
      rd(8'h04, 32'h0018_0400);
      irq_src_i = 4'h0;
      wr(8'h04, 4'h2, 32'h0000_0000);
      // The target is loaded before the enable, as the host must do.
      a_lo = $urandom;
      a_hi = $urandom;
      d_w = $urandom;
      wr(8'h74, 4'hf, a_lo);
      wr(8'h78, 4'hf, a_hi);
      wr(8'h7c, 4'hf, d_w);
      rd(8'h74, {a_lo[31:2], 2'b00});
      rd(8'h78, a_hi);
      rd(8'h7c, {16'h0, d_w[15:0]});
      wr(8'h70, 4'h4, 32'h0001_0000);
      rd(8'h70, 32'h0081_0000);
      for (int k = 0; k < 4; k++) begin
         slow = 2'($urandom_range(3, 0));
         irq_src_i = 4'($urandom_range(15, 1));
         mq.push_back({2'd2, a_hi, a_lo[31:2], 2'b00, d_w[15:0]});
         drain();
         rd(8'h04, 32'h0010_0000);
         irq_src_i = 4'h0;
         drain();
      end
      // A frozen block must not see the edge; it is taken once the enable returns.
      en = 1'b0;
      irq_src_i = 4'h1;
      drain();
      mq.push_back({2'd2, a_hi, a_lo[31:2], 2'b00, d_w[15:0]});
      en = 1'b1;
      drain();
      test_done();
   end
endmodule // pcie_intx_msi_signalling_tb_top
